// ==== core/see_exc_unit.sv ====
// Purpose: Synchronous exception entry and return sequencer
// Assumes: Pipeline holds the decoded instruction while stall is high
// Notes: Registers reached over AXI4-Lite
`include "see_defs.svh"
`default_nettype none
module see_exc_unit #(
  parameter int OPC_W = 8,
  parameter logic [(1<<OPC_W)-1:0] IMPL_MASK = '1
) (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic instr_valid, // Decoded instruction present
  input wire logic [OPC_W-1:0] instr_opcode, // Opcode field
  input wire see_pkg::see_kind_e instr_kind, // Instruction class
  input wire logic [31:0] instr_pc, // Instruction address
  input wire logic [1:0] mem_addr_lo, // Access address low bits
  input wire logic ext_irq_req, // External interrupt request
  output logic instr_kill, // Do not execute this instruction
  output logic mem_suppress, // Block its memory access
  output logic irq_take, // Interrupt may be accepted now
  output logic core_stall, // Hold pipeline, sequence running
  output logic redirect_valid, // Fetch from redirect_pc
  output logic [31:0] redirect_pc, // New fetch address
  output logic user_mode, // Live processor mode
  output logic int_enable, // Live interrupt enable
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  // ****************************************
  // Declarations
  // ****************************************
  see_pkg::see_state_e state_q, state_d;
  see_pkg::see_cause_e cause_q, cause_d;
  logic [31:0] fpc_q, fpc_d;
  logic [31:0] redir_q, redir_d;
  logic [4:0] live_q, live_d; // arith, copro, mode, ie, stsel
  logic [4:0] saved_q, saved_d;
  logic [31:0] retptr_q, retptr_d;
  logic [31:0] vbase_q, vbase_d;
  logic vb_lock_q, vb_lock_d;
  logic hold_q, hold_d;
  logic aw_hold_q, aw_hold_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic w_hold_q, w_hold_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic f_undef;
  logic f_align;
  logic f_priv;
  logic any_fault;
  logic idle;
  logic rte_go;
  logic wr_go;
  logic [31:0] status_rd;

  // Merge a write with its byte strobes
  function automatic logic [31:0] see_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Fault detection
  // ****************************************
  see_fault_check #(
    .OPC_W(OPC_W),
    .IMPL_MASK(IMPL_MASK)
  ) u_check (
    .valid(instr_valid && idle),
    .opcode(instr_opcode),
    .kind(instr_kind),
    .addr_lo(mem_addr_lo),
    .user_mode(live_q[`SEE_B_PMODE]),
    .bus_hold(hold_q),
    .undef(f_undef),
    .misalign(f_align),
    .priv(f_priv)
  );

  // Pipeline-facing handshakes
  assign idle = state_q == see_pkg::ST_IDLE;
  assign any_fault = f_undef || f_align || f_priv;
  assign rte_go = instr_valid && idle && !any_fault && instr_kind == see_pkg::KIND_RTE;
  assign instr_kill = any_fault;
  assign mem_suppress = f_align;
  // Fault always outranks a pending interrupt
  assign irq_take = ext_irq_req && live_q[`SEE_B_INTEN] && idle && !any_fault && !rte_go;
  assign core_stall = !idle;
  assign redirect_valid = state_q == see_pkg::ST_VEC || state_q == see_pkg::ST_RET;
  assign redirect_pc = redir_q;
  assign user_mode = live_q[`SEE_B_PMODE];
  assign int_enable = live_q[`SEE_B_INTEN];

  // ****************************************
  // Register bus handshakes
  // ****************************************
  // One write and one read in flight; no overlap hazards
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  assign status_rd = {19'h0, saved_q, 3'h0, live_q};

  // Bus slave next state
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (aw_addr_q <= `SEE_OFF_CTRL && aw_addr_q[1:0] == 2'h0) ? `SEE_RESP_OKAY : `SEE_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `SEE_RESP_OKAY;
      case (s_axi_araddr[7:0])
        `SEE_OFF_STATUS: rdata_d = status_rd;
        `SEE_OFF_RETPTR: rdata_d = retptr_q;
        `SEE_OFF_VBASE: rdata_d = vbase_q;
        `SEE_OFF_CTRL: rdata_d = {31'h0, hold_q};
        `SEE_OFF_CAUSE: rdata_d = {23'h0, !idle, 6'h0, cause_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `SEE_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SEE_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `SEE_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Status, pointer and entry sequencer
  // ****************************************
  // Software writes first; the sequencer overrides in the same cycle
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    state_d = state_q;
    cause_d = cause_q;
    fpc_d = fpc_q;
    redir_d = redir_q;
    live_d = live_q;
    saved_d = saved_q;
    retptr_d = retptr_q;
    vbase_d = vbase_q;
    vb_lock_d = vb_lock_q;
    hold_d = hold_q;
    if (wr_go) begin
      case (aw_addr_q)
        `SEE_OFF_STATUS: begin
          m = see_merge(status_rd, w_data_q, w_strb_q);
          live_d = m[4:0];
          saved_d = m[`SEE_B_SAVED +: 5];
        end
        `SEE_OFF_RETPTR: retptr_d = see_merge(retptr_q, w_data_q, w_strb_q);
        `SEE_OFF_VBASE: begin
          // Base may be moved only once per reset
          if (!vb_lock_q) begin
            vbase_d = see_merge(vbase_q, w_data_q, w_strb_q);
            vb_lock_d = 1'b1;
          end
        end
        `SEE_OFF_CTRL: begin
          if (w_strb_q[0]) begin
            hold_d = w_data_q[`SEE_B_HOLD];
          end
        end
        default: hold_d = hold_q;
      endcase
    end
    case (state_q)
      see_pkg::ST_IDLE: begin
        if (f_undef) begin
          cause_d = see_pkg::CAUSE_UNDEF;
          fpc_d = instr_pc;
          state_d = see_pkg::ST_SAVE;
        end else if (f_align) begin
          cause_d = see_pkg::CAUSE_ALIGN;
          fpc_d = instr_pc;
          state_d = see_pkg::ST_SAVE;
        end else if (f_priv) begin
          cause_d = see_pkg::CAUSE_PRIV;
          fpc_d = instr_pc;
          state_d = see_pkg::ST_SAVE;
        end else if (rte_go) begin
          // Resume at the aligned word holding the faulting op
          redir_d = {retptr_q[31], 1'b0, retptr_q[29:2], 2'h0};
          live_d = saved_q;
          state_d = see_pkg::ST_RET;
        end
      end
      see_pkg::ST_SAVE: begin
        saved_d = live_q;
        live_d = {live_q[`SEE_B_STSEL], 4'h0};
        // Faulting address itself, bit 30 marks a halfword slot
        retptr_d = {fpc_q[31], fpc_q[1], fpc_q[29:0]};
        case (cause_q)
          see_pkg::CAUSE_UNDEF: redir_d = vbase_q + `SEE_VEC_UNDEF;
          see_pkg::CAUSE_ALIGN: redir_d = vbase_q + `SEE_VEC_ALIGN;
          default: redir_d = vbase_q + `SEE_VEC_PRIV;
        endcase
        state_d = see_pkg::ST_VEC;
      end
      // Branch issued only after backups and pointer settle
      see_pkg::ST_VEC: state_d = see_pkg::ST_IDLE;
      see_pkg::ST_RET: state_d = see_pkg::ST_IDLE;
      default: state_d = see_pkg::ST_IDLE;
    endcase
  end

  // Sequencer and software-visible registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= see_pkg::ST_IDLE;
      cause_q <= see_pkg::CAUSE_NONE;
      fpc_q <= 32'h0000_0000;
      redir_q <= 32'h0000_0000;
      live_q <= `SEE_RST_STATUS;
      saved_q <= `SEE_RST_STATUS;
      retptr_q <= 32'h0000_0000;
      vbase_q <= `SEE_RST_VBASE;
      vb_lock_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      fpc_q <= fpc_d;
      redir_q <= redir_d;
      live_q <= live_d;
      saved_q <= saved_d;
      retptr_q <= retptr_d;
      vbase_q <= vbase_d;
      vb_lock_q <= vb_lock_d;
      hold_q <= hold_d;
    end
  end

endmodule // see_exc_unit
`default_nettype wire

// ==== core/see_defs.svh ====
// Purpose: Offsets, field positions, reset values and vector offsets
// Assumes: Included by the exception entry unit files
// Notes: Byte addresses on the register bus
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SEE_OFF_STATUS 8'h00
`define SEE_OFF_RETPTR 8'h04
`define SEE_OFF_VBASE 8'h08
`define SEE_OFF_CTRL 8'h0c
`define SEE_OFF_CAUSE 8'h10

// ****************************************
// Status, control, cause and return pointer field positions
// ****************************************
`define SEE_B_ARITH 0
`define SEE_B_COPRO 1
`define SEE_B_PMODE 2
`define SEE_B_INTEN 3
`define SEE_B_STSEL 4
`define SEE_B_SAVED 8
`define SEE_B_HOLD 0
`define SEE_B_BUSY 8
`define SEE_B_RETFLAG 30

// ****************************************
// Reset values, vector offsets and bus response codes
// ****************************************
`define SEE_RST_VBASE 32'h0000_0000
`define SEE_RST_STATUS 5'h00
`define SEE_VEC_UNDEF 32'h0000_0020
`define SEE_VEC_ALIGN 32'h0000_0030
`define SEE_VEC_PRIV 32'h0000_0100
`define SEE_RESP_OKAY 2'h0
`define SEE_RESP_SLVERR 2'h2

`endif

// ==== core/see_pkg.sv ====
// Purpose: Types shared by the exception entry unit
// Assumes: Nothing beyond the defs header
// Notes: Kind codes come from the core decoder
`default_nettype none
package see_pkg;

  // ****************************************
  // Instruction class from the decoder
  // ****************************************
  typedef enum logic [3:0] {
    KIND_OTHER, KIND_LDH, KIND_UNSIGNED_HALF_LOAD, KIND_STH, KIND_LD, KIND_ST,
    KIND_LOCK, KIND_UNLOCK, KIND_RTE, KIND_MOVE_TO_CTRL_REG, KIND_STATUS_BIT_SET, KIND_STATUS_BIT_CLEAR
  } see_kind_e;

  // Last accepted cause
  typedef enum logic [1:0] {
    CAUSE_NONE, CAUSE_UNDEF, CAUSE_ALIGN, CAUSE_PRIV
  } see_cause_e;

  // Entry and return sequencer
  typedef enum logic [1:0] {
    ST_IDLE, ST_SAVE, ST_VEC, ST_RET
  } see_state_e;

endpackage
`default_nettype wire

// ==== core/see_fault_check.sv ====
// Purpose: Combinational detection of the three synchronous faults
// Assumes: Inputs come from the decode stage on the same clock
// Notes: Undefined check looks at the opcode field alone
`default_nettype none
module see_fault_check #(
  parameter int OPC_W = 8,
  parameter logic [(1<<OPC_W)-1:0] IMPL_MASK = '1
) (
  input wire logic valid, // Decoded instruction present
  input wire logic [OPC_W-1:0] opcode, // Opcode field only
  input wire see_pkg::see_kind_e kind, // Instruction class
  input wire logic [1:0] addr_lo, // Low bits of access address
  input wire logic user_mode, // Processor in user mode
  input wire logic bus_hold, // Locked-sequence flag
  output logic undef, // Unimplemented opcode
  output logic misalign, // Misaligned access
  output logic priv // Privileged op in user mode
);

  logic half_op;
  logic word_op;
  logic half_bad;
  logic word_bad;
  logic priv_op;

  // ****************************************
  // Classification
  // ****************************************
  // Opcode mask lookup; other fields never enter here
  assign undef = valid && !IMPL_MASK[opcode];
  assign half_op = kind == see_pkg::KIND_LDH || kind == see_pkg::KIND_UNSIGNED_HALF_LOAD || kind == see_pkg::KIND_STH;
  // Unlock with the hold flag clear skips the check
  assign word_op = kind == see_pkg::KIND_LD || kind == see_pkg::KIND_ST || kind == see_pkg::KIND_LOCK
    || (kind == see_pkg::KIND_UNLOCK && bus_hold);
  assign half_bad = addr_lo[0];
  assign word_bad = addr_lo != 2'h0;
  assign priv_op = kind == see_pkg::KIND_RTE || kind == see_pkg::KIND_MOVE_TO_CTRL_REG
    || kind == see_pkg::KIND_STATUS_BIT_SET || kind == see_pkg::KIND_STATUS_BIT_CLEAR;

  // Undefined opcode masks the class-based checks
  assign misalign = valid && !undef && ((half_op && half_bad) || (word_op && word_bad));
  assign priv = valid && !undef && priv_op && user_mode;

endmodule // see_fault_check
`default_nettype wire

// ==== tb/see_pipe_model.sv ====
// Purpose: Pipeline side model that issues one decoded instruction
// Assumes: Core idle when issue is called
// Notes: Opcode, address and low-bit fields are scrambled once valid drops
`default_nettype none
module see_pipe_model (
  input wire logic aclk, // Core clock
  output logic instr_valid, // Instruction present
  output logic [7:0] instr_opcode, // Opcode field
  output see_pkg::see_kind_e instr_kind, // Class
  output logic [31:0] instr_pc, // Address
  output logic [1:0] mem_addr_lo, // Access low bits
  output logic ext_irq_req, // Interrupt request
  input wire logic instr_kill, // Kill
  input wire logic mem_suppress, // Suppress
  input wire logic irq_take, // Irq accepted
  input wire logic redirect_valid, // Redirect
  input wire logic [31:0] redirect_pc // Redirect target
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] fetch_pc;
  // Quiet pipeline at time zero
  initial begin
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_kind = see_pkg::KIND_OTHER;
    instr_pc = 32'h0;
    mem_addr_lo = 2'h0;
    ext_irq_req = 1'b0;
  end
  // Vector entry branch leads to handler
  always @(posedge aclk) if (redirect_valid) fetch_pc <= redirect_pc;
  // One instruction; dead opcode, address and low-bit fields inverted so stale data cannot pass
  task automatic issue(input logic [7:0] op, input see_pkg::see_kind_e k, input logic [31:0] pc,
                       input logic [1:0] lo, input logic irq, output logic kl, output logic sp,
                       output logic tk, output int lat, output logic [31:0] rp);
    lat = 0;
    rp = 32'h0;
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    instr_kind <= k;
    instr_pc <= pc;
    mem_addr_lo <= lo;
    ext_irq_req <= irq;
    @(negedge aclk);
    kl = instr_kill;
    sp = mem_suppress;
    tk = irq_take;
    @(posedge aclk);
    instr_valid <= 1'b0;
    instr_opcode <= ~op;
    instr_pc <= ~pc;
    mem_addr_lo <= ~lo;
    ext_irq_req <= 1'b0;
    for (int i = 1; i <= 4; i++) begin
      @(negedge aclk);
      if (redirect_valid && lat == 0) begin
        lat = i;
      end
    end
    // Target as the fetch side latched it, not the bare wire
    if (lat != 0) begin
      rp = fetch_pc;
    end
  endtask
endmodule // see_pipe_model
`default_nettype wire

// ==== tb/see_chk.sv ====
// Purpose: Port-level checks of fault entry and return
// Assumes: Vector base has its low nine bits clear
// Notes: Bound to see_exc_unit below
`default_nettype none
module see_chk #(
  parameter int OPC_W = 8,
  parameter logic [(1<<OPC_W)-1:0] IMPL_MASK = '1
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic instr_valid, // Valid
  input wire logic [OPC_W-1:0] instr_opcode, // Opcode
  input wire see_pkg::see_kind_e instr_kind, // Class
  input wire logic [1:0] mem_addr_lo, // Low bits
  input wire logic ext_irq_req, // Irq
  input wire logic instr_kill, // Kill
  input wire logic mem_suppress, // Suppress
  input wire logic irq_take, // Take
  input wire logic core_stall, // Stall
  input wire logic redirect_valid, // Redirect
  input wire logic [31:0] redirect_pc, // Target
  input wire logic user_mode, // Mode
  input wire logic int_enable // Ie
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Decode helpers
  // ****************************************
  logic go, undef, half_k, word_k, priv_k;
  assign go = instr_valid && !core_stall;
  assign undef = !IMPL_MASK[instr_opcode];
  assign half_k = instr_kind inside {see_pkg::KIND_LDH, see_pkg::KIND_UNSIGNED_HALF_LOAD, see_pkg::KIND_STH};
  assign word_k = instr_kind inside {see_pkg::KIND_LD, see_pkg::KIND_ST, see_pkg::KIND_LOCK};
  assign priv_k = instr_kind inside {see_pkg::KIND_RTE, see_pkg::KIND_MOVE_TO_CTRL_REG, see_pkg::KIND_STATUS_BIT_SET,
                                     see_pkg::KIND_STATUS_BIT_CLEAR};
  sequence s_entry;
    core_stall && !redirect_valid ##1 core_stall && redirect_valid ##1 !core_stall;
  endsequence
  sequence s_ret;
    core_stall && redirect_valid && redirect_pc[30] == 1'b0 && redirect_pc[1:0] == 2'b00 ##1 !core_stall;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_UNDEF: assert property (go && undef |->
    instr_kill ##2 redirect_valid && redirect_pc[7:0] == 8'h20)
    else $error("undefined opcode entry wrong");
  AST_HALF: assert property (go && !undef && half_k && mem_addr_lo[0] |->
    instr_kill && mem_suppress ##2 redirect_pc[7:0] == 8'h30)
    else $error("halfword misalign entry wrong");
  AST_WORD: assert property (go && !undef && word_k && mem_addr_lo != 2'b00 |->
    instr_kill && mem_suppress ##2 redirect_pc[7:0] == 8'h30)
    else $error("word misalign entry wrong");
  AST_PRIV: assert property (go && !undef && priv_k && user_mode |->
    instr_kill ##2 redirect_pc[8:0] == 9'h100)
    else $error("privilege entry wrong");
  AST_ENTRY: assert property (go && instr_kill |=> s_entry)
    else $error("entry sequence order wrong");
  AST_CLEAR: assert property (go && instr_kill |-> ##2 !user_mode && !int_enable)
    else $error("mode or enable not cleared");
  AST_IRQ: assert property (go && ext_irq_req && instr_kill |-> !irq_take ##1 core_stall)
    else $error("interrupt taken over fault");
  AST_RET: assert property (go && !undef && instr_kind == see_pkg::KIND_RTE && !user_mode |=> s_ret)
    else $error("return redirect wrong");
endmodule // see_chk
bind see_exc_unit see_chk #(.OPC_W(OPC_W), .IMPL_MASK(IMPL_MASK)) see_chk_i (.aclk, .aresetn, .instr_valid,
  .instr_opcode, .instr_kind, .mem_addr_lo, .ext_irq_req, .instr_kill, .mem_suppress, .irq_take,
  .core_stall, .redirect_valid, .redirect_pc, .user_mode, .int_enable);
`default_nettype wire

// ==== tb/test_see_exc_unit.sv ====
// Purpose: Self-checking bench of the exception entry unit
// Assumes: Opcode 8'hff is the only unimplemented one
// Notes: Random traffic from a fixed xorshift seed
`include "see_defs.svh"
`default_nettype none
module test_see_exc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, a); end end
  localparam logic [255:0] MASK = {1'b0, {255{1'b1}}};
  localparam logic [31:0] VB0 = 32'h0001_0000;
  localparam logic [1:0] OK = `SEE_RESP_OKAY;
  localparam logic [1:0] ERR = `SEE_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic instr_valid, ext_irq_req, instr_kill, mem_suppress, irq_take, core_stall, redirect_valid;
  logic user_mode, int_enable, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] instr_opcode;
  see_pkg::see_kind_e instr_kind;
  logic [31:0] instr_pc, redirect_pc, s_axi_rdata;
  logic [1:0] mem_addr_lo, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] seed = 32'h4fdbd682;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 aclk = ~aclk;
  see_exc_unit #(.OPC_W(8), .IMPL_MASK(MASK)) see_exc_unit_i (.aclk, .aresetn, .instr_valid, .instr_opcode,
    .instr_kind, .instr_pc, .mem_addr_lo, .ext_irq_req, .instr_kill, .mem_suppress, .irq_take, .core_stall,
    .redirect_valid, .redirect_pc, .user_mode, .int_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  see_pipe_model see_pipe_model_i (.aclk, .instr_valid, .instr_opcode, .instr_kind, .instr_pc, .mem_addr_lo,
    .ext_irq_req, .instr_kill, .mem_suppress, .irq_take, .redirect_valid, .redirect_pc);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected misalign verdict per access class
  function automatic logic mis(see_pkg::see_kind_e k, logic [1:0] lo, logic hold);
    case (k)
      see_pkg::KIND_LDH, see_pkg::KIND_UNSIGNED_HALF_LOAD, see_pkg::KIND_STH: return lo[0];
      see_pkg::KIND_LD, see_pkg::KIND_ST, see_pkg::KIND_LOCK: return |lo;
      see_pkg::KIND_UNLOCK: return hold && |lo;
      default: return 1'b0;
    endcase
  endfunction
  // Ready sampled mid-cycle; release lands on the handshake edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    `CHK("bresp", er, r)
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    `CHK("rdata", e, d)
    `CHK("rresp", er, r)
  endtask
  // One instruction; lat 2 means fault entry, 1 return, 0 none
  task automatic run(input logic [7:0] op, input see_pkg::see_kind_e k, input logic [31:0] pc, input logic [1:0] lo,
                     input logic irq, input logic [31:0] ev, input int el, input logic es, input logic et);
    logic kl, sp, tk;
    int lat;
    logic [31:0] rp;
    see_pipe_model_i.issue(op, k, pc, lo, irq, kl, sp, tk, lat, rp);
    `CHK("kill", el == 2, kl)
    `CHK("suppress", es, sp)
    `CHK("irq_take", et, tk)
    `CHK("latency", el, lat)
    if (el != 0) `CHK("redirect", ev, rp)
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the fewer than one thousand cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic u, f, ie;
    see_pkg::see_kind_e k;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SEE_OFF_STATUS, 32'h0, OK);
    rd(`SEE_OFF_VBASE, `SEE_RST_VBASE, OK);
    rd(32'h14, 32'h0, ERR);
    wr(`SEE_OFF_CAUSE, 32'h0, ERR);
    wr(`SEE_OFF_STATUS, 32'h1f, OK);
    run(8'hff, see_pkg::KIND_OTHER, 32'h6, 2'h0, 1'b1, 32'h20, 2, 1'b0, 1'b0);
    rd(`SEE_OFF_STATUS, 32'h1f10, OK);
    rd(`SEE_OFF_RETPTR, 32'h4000_0006, OK);
    rd(`SEE_OFF_CAUSE, 32'h1, OK);
    wr(`SEE_OFF_VBASE, VB0, OK);
    wr(`SEE_OFF_VBASE, 32'h7000_0000, OK);
    rd(`SEE_OFF_VBASE, VB0, OK);
    wr(`SEE_OFF_CTRL, 32'h1, OK);
    rd(`SEE_OFF_CTRL, 32'h1, OK);
    for (int i = 1; i <= 7; i++) begin
      for (int lo = 0; lo < 4; lo++) begin
        k = see_pkg::see_kind_e'(i);
        f = mis(k, 2'(lo), 1'b1);
        wr(`SEE_OFF_STATUS, 32'h8, OK);
        run(8'h10, k, 32'h300, 2'(lo), 1'b1, VB0 + 32'h30, f ? 2 : 0, f,
            !f);
      end
    end
    rd(`SEE_OFF_RETPTR, 32'h0000_0300, OK);
    rd(`SEE_OFF_CAUSE, 32'h2, OK);
    wr(`SEE_OFF_CTRL, 32'h0, OK);
    run(8'h10, see_pkg::KIND_UNLOCK, 32'h300, 2'h1, 1'b0, 32'h0, 0, 1'b0, 1'b0);
    for (int i = 8; i <= 11; i++) begin
      wr(`SEE_OFF_STATUS, 32'hc, OK);
      run(8'h20, see_pkg::see_kind_e'(i), 32'h2002, 2'h0, 1'b1, VB0 + 32'h100, 2, 1'b0,
          1'b0);
    end
    rd(`SEE_OFF_CAUSE, 32'h3, OK);
    // Handler saves context, then restores it before returning
    wr(`SEE_OFF_STATUS, 32'h1b, OK);
    run(8'h30, see_pkg::KIND_LD, 32'h1006, 2'h2, 1'b0, VB0 + 32'h30, 2, 1'b1, 1'b0);
    rd(`SEE_OFF_RETPTR, 32'h4000_1006, OK);
    wr(`SEE_OFF_RETPTR, 32'h4000_1006, OK);
    wr(`SEE_OFF_STATUS, 32'h1b10, OK);
    run(8'h40, see_pkg::KIND_RTE, 32'h0001_0040, 2'h0, 1'b0, 32'h1004, 1, 1'b0, 1'b0);
    `CHK("int_enable", 1'b1, int_enable)
    `CHK("user_mode", 1'b0, user_mode)
    // Byte strobe: only the live byte moves, saved copies stay
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(`SEE_OFF_STATUS, 32'h1f08, OK);
    s_axi_wstrb <= 4'hf;
    rd(`SEE_OFF_STATUS, 32'h1b08, OK);
    // Random traffic in supervisor mode; a fault turns interrupts off until a status write
    ie = 1'b1;
    repeat (40) begin
      r = xs();
      u = r[2:0] == 3'h0;
      k = u ? see_pkg::KIND_OTHER : see_pkg::see_kind_e'({1'b0, r[18:16]});
      f = u || mis(k, r[21:20], 1'b0);
      run(u ? 8'hff : {1'b0, r[14:8]}, k, xs(), r[21:20], r[24], VB0 + (u ? 32'h20 : 32'h30), f ? 2 : 0,
          !u && f, r[24] && ie && !f);
      if (f) ie = 1'b0;
      if (!ie && r[28]) begin
        wr(`SEE_OFF_STATUS, 32'h8, OK);
        ie = 1'b1;
      end
    end
    summarize();
  end
endmodule // test_see_exc_unit
`default_nettype wire
